// File: ssq_consts.svh
// Register offsets, frame numbers, codes and counts of the slip status and signaling queue
`ifndef SSQ_CONSTS_SVH
`define SSQ_CONSTS_SVH
`define SSQ_ADDR_SYNC_FRAME   8'hd8
`define SSQ_ADDR_SLIP_STATUS  8'hd9
`define SSQ_ADDR_SIG_QUEUE    8'hda
`define SSQ_RDATA_UNMAPPED    8'h00
`define SSQ_OFFSET_RESET      5'h00
`define SSQ_OFFSET_E1_MASK    5'h0f
`define SSQ_FRAME_STEP        5'h01
`define SSQ_T1_FIRST_FRAME    5'h01
`define SSQ_T1_LAST_FRAME     5'h18
`define SSQ_E1_FIRST_FRAME    5'h00
`define SSQ_E1_LAST_FRAME     5'h0f
`define SSQ_T1_SIG_FRAME_A    5'h06
`define SSQ_T1_SIG_FRAME_B    5'h0c
`define SSQ_T1_SIG_FRAME_C    5'h12
`define SSQ_T1_SIG_FRAME_D    5'h18
`define SSQ_QUEUE_DEPTH       32
`define SSQ_WORD_EMPTY        8'h00
`define SSQ_WORD_ID_FIRST     1'b0
`define SSQ_WORD_ID_SECOND    1'b1
`define SSQ_WORD_MORE_FIRST   1'b1
`endif

// File: ssq_pkg.sv
// Types shared by the slip status and signaling queue modules
package ssq_pkg;
  typedef enum logic [1:0] {
    SSQ_MODE_NORMAL,
    SSQ_MODE_SHORT,
    SSQ_MODE_ELASTIC,
    SSQ_MODE_BYPASS
  } ssq_bus_mode_e;

  typedef enum logic {
    SSQ_PHASE_FIRST,
    SSQ_PHASE_SECOND
  } ssq_phase_e;

  typedef struct packed {
    logic [4:0] offset;
    logic [4:0] frame;
    logic       mf_out;
    logic       sig_frame;
    logic       rx_pf;
    logic       rx_pu;
    logic       rx_pdir;
    logic       rx_dir;
    logic       rx_err;
    logic       tx_pf;
    logic       tx_pu;
    logic       tx_pdir;
    logic       tx_dir;
    logic       tx_err;
    logic       mf_changed;
    logic       sig_irq;
    logic [7:0] rdata;
  } ssq_main_state_s;
endpackage

// File: ssq_sticky.sv
// Group of sticky flags: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module ssq_sticky #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Set and clear
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  // Flags
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] flags;
  } ssq_sticky_state_s;

  ssq_sticky_state_s st_ff;
  ssq_sticky_state_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // A read that meets a new event must not lose it
    nxt_st.flags = (clr ? '0 : st_ff.flags) | set;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.flags;
endmodule
`default_nettype wire

// File: ssq_queue.sv
// Signaling change queue read as channel word then signaling word
`timescale 1ns/1ps
`default_nettype none
`include "ssq_consts.svh"
module ssq_queue import ssq_pkg::*; #(
  parameter int DEPTH = `SSQ_QUEUE_DEPTH
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       flush,
  // Fill side
  input  wire logic       push,
  input  wire logic [4:0] push_chan,
  input  wire logic [3:0] push_abcd,
  // Processor side
  input  wire logic       rd,
  output logic      [7:0] word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_CNT  = CW'(1);

  typedef struct packed {
    logic [DEPTH-1:0][8:0] mem;
    logic [PW-1:0]         wr_ptr;
    logic [PW-1:0]         rd_ptr;
    logic [CW-1:0]         count;
    ssq_phase_e            phase;
  } ssq_queue_state_s;

  ssq_queue_state_s st_ff;
  ssq_queue_state_s nxt_st;
  logic             empty;
  logic             do_push;
  logic             do_pop;
  logic [8:0]       head;

  assign empty = (st_ff.count == '0);
  assign head  = st_ff.mem[st_ff.rd_ptr];

  always_comb begin
    nxt_st  = st_ff;
    do_pop  = 1'b0;
    // Depth covers every channel once per multiframe, so a full drop means overrun
    do_push = push && (st_ff.count != FULL_CNT);
    if (empty) begin
      word = `SSQ_WORD_EMPTY;
    end else if (st_ff.phase == SSQ_PHASE_FIRST) begin
      word = {`SSQ_WORD_ID_FIRST, `SSQ_WORD_MORE_FIRST, 1'b0, head[8:4]};
    end else begin
      word = {`SSQ_WORD_ID_SECOND, (st_ff.count > ONE_CNT), 2'b00, head[3:0]};
    end
    if (rd && !empty) begin
      if (st_ff.phase == SSQ_PHASE_FIRST) begin
        nxt_st.phase = SSQ_PHASE_SECOND;
      end else begin
        nxt_st.phase  = SSQ_PHASE_FIRST;
        do_pop        = 1'b1;
        nxt_st.rd_ptr = (st_ff.rd_ptr == LAST_PTR) ? '0 : st_ff.rd_ptr + PW'(1);
      end
    end
    if (do_push) begin
      nxt_st.mem[st_ff.wr_ptr] = {push_chan, push_abcd};
      nxt_st.wr_ptr = (st_ff.wr_ptr == LAST_PTR) ? '0 : st_ff.wr_ptr + PW'(1);
    end
    nxt_st.count = st_ff.count + CW'(do_push) - CW'(do_pop);
    if (flush) begin
      nxt_st.wr_ptr = '0;
      nxt_st.rd_ptr = '0;
      nxt_st.count  = '0;
      nxt_st.phase  = SSQ_PHASE_FIRST;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_FLUSH_EMPTIES: assert property (flush |=> word == `SSQ_WORD_EMPTY)
    else $error("queue not empty after flush");
  AST_WORD_ALTERNATES: assert property (
    rd && !flush && !empty && st_ff.phase == SSQ_PHASE_FIRST |=> word[7])
    else $error("second word did not follow first word");
  AST_NO_PUSH_STABLE: assert property (
    !push && !rd && !flush |=> $stable(st_ff.count))
    else $error("queue count moved without push or read");
  COV_TWO_ENTRIES: cover property (push ##1 push ##1 rd ##1 rd);
endmodule
`default_nettype wire

// File: ssq_top.sv
// Sync frame offset, slip event status and signaling change queue registers
`timescale 1ns/1ps
`default_nettype none
`include "ssq_consts.svh"
module ssq_top import ssq_pkg::*; #(
  parameter int QUEUE_DEPTH = `SSQ_QUEUE_DEPTH
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Processor register port
  input  wire logic    [7:0] cpu_addr,
  input  wire logic          cpu_wr,
  input  wire logic          cpu_rd,
  input  wire logic    [7:0] cpu_wdata,
  output logic         [7:0] cpu_rdata,
  input  wire logic          soft_reset,
  // Receive system bus framing
  input  wire logic          carrier_mode_select,
  input  wire logic          rx_bus_frame_start,
  input  wire logic          rx_multiframe_sync_in,
  input  wire logic          rx_multiframe_sync_is_out,
  output logic               rx_multiframe_sync_out,
  output logic         [4:0] rx_frame_number,
  input  wire logic          rx_channel_insert_en,
  output logic               rx_pcm_sig_insert,
  // Receive slip events
  input  var  ssq_bus_mode_e rx_bus_config,
  input  wire logic          rx_frame_boundary,
  input  wire logic          rx_frame_slip_evt,
  input  wire logic          rx_frame_slip_repeat,
  input  wire logic          rx_bus_resync_evt,
  input  wire logic          rx_slot_reassign_evt,
  output logic               rx_slip_error,
  // Transmit slip events
  input  var  ssq_bus_mode_e tx_bus_config,
  input  wire logic          tx_frame_boundary,
  input  wire logic          tx_frame_slip_evt,
  input  wire logic          tx_frame_slip_repeat,
  input  wire logic          tx_bit_slip_evt,
  output logic               tx_slip_error,
  // Signaling evaluation
  input  wire logic          sig_eval_valid,
  input  wire logic    [4:0] channel_index,
  input  wire logic          per_channel_queue_enable,
  input  wire logic    [3:0] sig_in_abcd,
  input  wire logic    [3:0] sig_out_abcd,
  input  wire logic          rx_multiframe_end,
  output logic               signaling_change_interrupt
);
  ssq_main_state_s st_ff;
  ssq_main_state_s nxt_st;
  logic [4:0]      target;
  logic [4:0]      first_frame;
  logic [4:0]      last_frame;
  logic            slip_read;
  logic            queue_read;
  logic            queue_push;
  logic [7:0]      queue_word;
  logic            rx_f_ok;
  logic            rx_u_ok;
  logic            tx_f_ok;
  logic            tx_u_ok;
  logic            rx_post_f;
  logic            rx_post_u;
  logic            tx_post_f;
  logic            tx_post_u;
  logic [1:0]      rx_flags;
  logic [1:0]      tx_flags;

  assign slip_read  = cpu_rd && (cpu_addr == `SSQ_ADDR_SLIP_STATUS);
  assign queue_read = cpu_rd && (cpu_addr == `SSQ_ADDR_SIG_QUEUE);
  // Debounced output is compared with buffered input after the D bit
  assign queue_push = sig_eval_valid && per_channel_queue_enable &&
                      (sig_in_abcd != sig_out_abcd);

  // Mode gating: the slip buffer classifies slips, this block filters by mode
  assign rx_f_ok = (rx_bus_config == SSQ_MODE_NORMAL) ||
                   (rx_bus_config == SSQ_MODE_SHORT);
  assign rx_u_ok = (rx_bus_config != SSQ_MODE_BYPASS);
  assign tx_f_ok = (tx_bus_config == SSQ_MODE_NORMAL) ||
                   (tx_bus_config == SSQ_MODE_SHORT);
  assign tx_u_ok = (tx_bus_config != SSQ_MODE_BYPASS);

  always_comb begin
    nxt_st = st_ff;
    // Sync frame selection
    if (carrier_mode_select) begin
      target      = st_ff.offset + `SSQ_FRAME_STEP;
      first_frame = `SSQ_T1_FIRST_FRAME;
      last_frame  = `SSQ_T1_LAST_FRAME;
    end else begin
      target      = st_ff.offset & `SSQ_OFFSET_E1_MASK;
      first_frame = `SSQ_E1_FIRST_FRAME;
      last_frame  = `SSQ_E1_LAST_FRAME;
    end
    if (cpu_wr && (cpu_addr == `SSQ_ADDR_SYNC_FRAME)) begin
      nxt_st.offset = cpu_wdata[4:0];
    end
    // Counter follows bus frames only; a controlled slip never moves it
    if (rx_bus_frame_start) begin
      if (!rx_multiframe_sync_is_out && rx_multiframe_sync_in) begin
        nxt_st.frame = target;
      end else if (st_ff.frame >= last_frame) begin
        nxt_st.frame = first_frame;
      end else begin
        nxt_st.frame = st_ff.frame + `SSQ_FRAME_STEP;
      end
    end
    nxt_st.mf_out = rx_multiframe_sync_is_out && (nxt_st.frame == target);
    if (carrier_mode_select) begin
      nxt_st.sig_frame = (nxt_st.frame == `SSQ_T1_SIG_FRAME_A) ||
                         (nxt_st.frame == `SSQ_T1_SIG_FRAME_B) ||
                         (nxt_st.frame == `SSQ_T1_SIG_FRAME_C) ||
                         (nxt_st.frame == `SSQ_T1_SIG_FRAME_D);
    end else begin
      // Frame 0 carries multiframe alignment, not signaling
      nxt_st.sig_frame = (nxt_st.frame != `SSQ_E1_FIRST_FRAME);
    end

    // Receive slips gather between boundaries
    nxt_st.rx_pf = st_ff.rx_pf | (rx_frame_slip_evt & rx_f_ok);
    nxt_st.rx_pu = st_ff.rx_pu | ((rx_bus_resync_evt | rx_slot_reassign_evt) & rx_u_ok);
    if (rx_frame_slip_evt && rx_f_ok) begin
      nxt_st.rx_pdir = rx_frame_slip_repeat;
    end else if (rx_slot_reassign_evt && rx_u_ok) begin
      nxt_st.rx_pdir = 1'b1;
    end else if (rx_bus_resync_evt && rx_u_ok) begin
      nxt_st.rx_pdir = 1'b0;
    end
    // Mode also gates the post, so a late mode change cannot set a barred flag
    rx_post_f     = rx_frame_boundary && nxt_st.rx_pf && rx_f_ok;
    rx_post_u     = rx_frame_boundary && nxt_st.rx_pu && rx_u_ok;
    nxt_st.rx_err = rx_post_f || rx_post_u;
    if (rx_frame_boundary) begin
      if (rx_post_f || rx_post_u) begin
        nxt_st.rx_dir = nxt_st.rx_pdir;
      end
      nxt_st.rx_pf = 1'b0;
      nxt_st.rx_pu = 1'b0;
    end

    // Transmit slips: a controlled slip shifts frames, timebase untouched
    nxt_st.tx_pf = st_ff.tx_pf | (tx_frame_slip_evt & tx_f_ok);
    nxt_st.tx_pu = st_ff.tx_pu | (tx_bit_slip_evt & tx_u_ok);
    if (tx_frame_slip_evt && tx_f_ok) begin
      nxt_st.tx_pdir = tx_frame_slip_repeat;
    end
    tx_post_f     = tx_frame_boundary && nxt_st.tx_pf && tx_f_ok;
    tx_post_u     = tx_frame_boundary && nxt_st.tx_pu && tx_u_ok;
    nxt_st.tx_err = tx_post_f || tx_post_u;
    if (tx_frame_boundary) begin
      if (tx_post_f) begin
        nxt_st.tx_dir = nxt_st.tx_pdir;
      end
      nxt_st.tx_pf = 1'b0;
      nxt_st.tx_pu = 1'b0;
    end

    // Change seen this multiframe; a push on the closing cycle still counts
    nxt_st.sig_irq = rx_multiframe_end && (st_ff.mf_changed || queue_push);
    if (rx_multiframe_end) begin
      nxt_st.mf_changed = 1'b0;
    end else if (queue_push) begin
      nxt_st.mf_changed = 1'b1;
    end

    // Read data holds the value before any read side effect
    if (!cpu_rd) begin
      nxt_st.rdata = st_ff.rdata;
    end else if (cpu_addr == `SSQ_ADDR_SYNC_FRAME) begin
      nxt_st.rdata = {3'h0, st_ff.offset};
    end else if (cpu_addr == `SSQ_ADDR_SLIP_STATUS) begin
      nxt_st.rdata = {st_ff.tx_dir, tx_flags, 1'b0, st_ff.rx_dir, rx_flags, 1'b0};
    end else if (cpu_addr == `SSQ_ADDR_SIG_QUEUE) begin
      nxt_st.rdata = queue_word;
    end else begin
      nxt_st.rdata = `SSQ_RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ssq_sticky #(
    .W (2)
  ) u_rx_flags (
    .clk   (clk),
    .reset (reset),
    .set   ({rx_post_f, rx_post_u}),
    .clr   (slip_read),
    .q     (rx_flags)
  );

  ssq_sticky #(
    .W (2)
  ) u_tx_flags (
    .clk   (clk),
    .reset (reset),
    .set   ({tx_post_f, tx_post_u}),
    .clr   (slip_read),
    .q     (tx_flags)
  );

  ssq_queue #(
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .clk       (clk),
    .reset     (reset),
    .flush     (soft_reset),
    .push      (queue_push),
    .push_chan (channel_index),
    .push_abcd (sig_in_abcd),
    .rd        (queue_read),
    .word      (queue_word)
  );

  assign cpu_rdata                  = st_ff.rdata;
  assign rx_multiframe_sync_out     = st_ff.mf_out;
  assign rx_frame_number            = st_ff.frame;
  // Insertion is per channel, so it stays combinational on the enable
  assign rx_pcm_sig_insert          = rx_channel_insert_en && st_ff.sig_frame;
  assign rx_slip_error              = st_ff.rx_err;
  assign tx_slip_error              = st_ff.tx_err;
  assign signaling_change_interrupt = st_ff.sig_irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_T1_OFFSET_LOAD: assert property (
    carrier_mode_select && rx_bus_frame_start && rx_multiframe_sync_in &&
    !rx_multiframe_sync_is_out && !cpu_wr ##1 carrier_mode_select |->
    rx_frame_number == st_ff.offset + `SSQ_FRAME_STEP)
    else $error("T1 frame not loaded to offset plus one");
  AST_MF_OUT_AT_TARGET: assert property (
    rx_multiframe_sync_out |-> $past(rx_multiframe_sync_is_out) &&
    rx_frame_number == $past(target))
    else $error("sync out while sync pin is input");
  AST_INSERT_GATED: assert property (
    !rx_channel_insert_en |-> !rx_pcm_sig_insert)
    else $error("insertion on a disabled channel");
  AST_SET_AT_BOUNDARY: assert property (
    $rose(rx_flags[1]) |-> $past(rx_frame_boundary))
    else $error("receive flag set away from frame boundary");
  AST_HOLD_TILL_READ: assert property (
    tx_flags[1] && !slip_read |=> tx_flags[1])
    else $error("transmit flag dropped without read");
  AST_TX_DIRECTION: assert property (
    tx_frame_boundary && tx_frame_slip_evt && tx_f_ok |=>
    st_ff.tx_dir == $past(tx_frame_slip_repeat))
    else $error("transmit direction not updated");
  AST_TX_ERROR: assert property (
    $rose(tx_flags[0]) |-> tx_slip_error)
    else $error("transmit slip error missing");
  AST_TX_CTRL_ZERO: assert property (
    tx_frame_boundary && !tx_f_ok && !tx_flags[1] && !slip_read ##1 !tx_f_ok |->
    !tx_flags[1])
    else $error("transmit controlled flag set in bypass or elastic");
  AST_RX_RESYNC_DIR: assert property (
    rx_frame_boundary && rx_bus_resync_evt && !rx_slot_reassign_evt &&
    !rx_frame_slip_evt && rx_u_ok |=> !st_ff.rx_dir)
    else $error("resync did not give direction 0");
  AST_CHANGE_IRQ: assert property (
    rx_multiframe_end && queue_push |=> signaling_change_interrupt ##1
    !signaling_change_interrupt)
    else $error("change interrupt not a single pulse");
  AST_RX_ERROR: assert property (
    rx_slip_error |-> $past(rx_frame_boundary))
    else $error("receive slip error away from boundary");
  AST_E1_OFFSET_LOAD: assert property (
    !carrier_mode_select && rx_bus_frame_start && rx_multiframe_sync_in &&
    !rx_multiframe_sync_is_out && !cpu_wr |=>
    rx_frame_number == (st_ff.offset & `SSQ_OFFSET_E1_MASK))
    else $error("E1 frame not loaded to offset low bits");
  AST_OFFSET_WRITE: assert property (
    cpu_wr && (cpu_addr == `SSQ_ADDR_SYNC_FRAME) |=>
    st_ff.offset == $past(cpu_wdata[4:0]))
    else $error("offset write not stored");
  AST_T1_SIG_FRAMES: assert property (
    rx_pcm_sig_insert && $past(carrier_mode_select) |->
    rx_frame_number inside {`SSQ_T1_SIG_FRAME_A, `SSQ_T1_SIG_FRAME_B,
                            `SSQ_T1_SIG_FRAME_C, `SSQ_T1_SIG_FRAME_D})
    else $error("T1 insertion outside a signaling frame");
  AST_E1_SIG_FRAMES: assert property (
    rx_pcm_sig_insert && !$past(carrier_mode_select) |->
    rx_frame_number != `SSQ_E1_FIRST_FRAME)
    else $error("E1 insertion in alignment frame");
  AST_FRAME_STABLE: assert property (
    !rx_bus_frame_start |=> $stable(rx_frame_number))
    else $error("frame number moved without a bus frame");
  AST_TX_SET_AT_BOUNDARY: assert property (
    $rose(tx_flags[1]) |-> $past(tx_frame_boundary))
    else $error("transmit flag set away from frame boundary");
  AST_READ_CLEARS: assert property (
    slip_read && !rx_frame_boundary && !tx_frame_boundary |=>
    rx_flags == '0 && tx_flags == '0)
    else $error("slip flags not cleared by read");
  AST_RX_HOLD_TILL_READ: assert property (
    rx_flags[0] && !slip_read |=> rx_flags[0])
    else $error("receive flag dropped without read");
  AST_TX_UNCTRL_VOID: assert property (
    tx_frame_boundary && !tx_u_ok && !tx_flags[0] && !slip_read |=>
    !tx_flags[0])
    else $error("transmit uncontrolled flag set in bypass");
  AST_RX_DIRECTION: assert property (
    rx_frame_boundary && rx_frame_slip_evt && rx_f_ok |=>
    st_ff.rx_dir == $past(rx_frame_slip_repeat))
    else $error("receive direction not updated");
  AST_RX_REASSIGN_DIR: assert property (
    rx_frame_boundary && rx_slot_reassign_evt && !rx_frame_slip_evt && rx_u_ok |=>
    st_ff.rx_dir)
    else $error("slot reassignment did not give direction 1");
  AST_RX_CTRL_ZERO: assert property (
    rx_frame_boundary && !rx_f_ok && !rx_flags[1] && !slip_read |=>
    !rx_flags[1])
    else $error("receive controlled flag set in bypass or elastic");
  AST_IRQ_AT_END: assert property (
    signaling_change_interrupt |-> $past(rx_multiframe_end))
    else $error("change interrupt away from multiframe end");

  COV_RX_SLIP_READ: cover property (rx_slip_error ##[1:20] slip_read);
  COV_TX_REPEAT: cover property (tx_slip_error && st_ff.tx_dir);
  COV_CHANGE_IRQ: cover property (queue_push ##[1:50] signaling_change_interrupt);
  COV_MF_OUT: cover property (rx_multiframe_sync_out);
endmodule
`default_nettype wire

// File: ssq_testbench.sv
// Self-checking bench for the slip status and signaling queue block
`timescale 1ns/1ps
`default_nettype none
`include "ssq_consts.svh"
module testbench import ssq_pkg::*;;
  logic          clk, reset, cpu_wr, cpu_rd, soft_reset, mode_t1, fstart;
  logic          sync_in, sync_is_out, sync_out, insert_en, sig_ins;
  logic          rx_bnd, rx_fs, rx_rep, rx_resync, rx_reass, rx_err;
  logic          tx_bnd, tx_fs, tx_rep, tx_bit, tx_err;
  logic          eval, q_en, mf_end, sig_irq;
  logic    [7:0] cpu_addr, cpu_wdata, cpu_rdata, last_st;
  logic    [4:0] frame_no, chan;
  logic    [3:0] abcd_in, abcd_out;
  logic   [11:0] rows [7];
  ssq_bus_mode_e rx_cfg, tx_cfg;
  int            error_cnt, comparisons;

  // Small depth so the full case is cheap to reach
  ssq_top #(.QUEUE_DEPTH(4)) dut_u (
    .clk(clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .soft_reset(soft_reset),
    .carrier_mode_select(mode_t1), .rx_bus_frame_start(fstart),
    .rx_multiframe_sync_in(sync_in), .rx_multiframe_sync_is_out(sync_is_out),
    .rx_multiframe_sync_out(sync_out), .rx_frame_number(frame_no),
    .rx_channel_insert_en(insert_en), .rx_pcm_sig_insert(sig_ins),
    .rx_bus_config(rx_cfg), .rx_frame_boundary(rx_bnd), .rx_frame_slip_evt(rx_fs),
    .rx_frame_slip_repeat(rx_rep), .rx_bus_resync_evt(rx_resync),
    .rx_slot_reassign_evt(rx_reass), .rx_slip_error(rx_err), .tx_bus_config(tx_cfg),
    .tx_frame_boundary(tx_bnd), .tx_frame_slip_evt(tx_fs), .tx_frame_slip_repeat(tx_rep),
    .tx_bit_slip_evt(tx_bit), .tx_slip_error(tx_err), .sig_eval_valid(eval),
    .channel_index(chan), .per_channel_queue_enable(q_en), .sig_in_abcd(abcd_in),
    .sig_out_abcd(abcd_out), .rx_multiframe_end(mf_end),
    .signaling_change_interrupt(sig_irq));

  always #2.5 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    chk(cpu_rdata, exp, what);
  endtask

  task automatic frame(input logic s);
    @(negedge clk);
    fstart = 1'b1;
    sync_in = s;
    @(negedge clk);
    fstart = 1'b0;
    sync_in = 1'b0;
  endtask

  // Events are gathered and only posted at the boundary; direction bits survive reads
  task automatic slip(input logic [6:0] ev, input logic [7:0] exp);
    @(negedge clk);
    {rx_fs, rx_rep, rx_resync, rx_reass, tx_fs, tx_rep, tx_bit} = ev;
    @(negedge clk);
    {rx_fs, rx_rep, rx_resync, rx_reass, tx_fs, tx_rep, tx_bit} = 7'h00;
    rd(`SSQ_ADDR_SLIP_STATUS, last_st & 8'h88, "status before boundary");
    @(negedge clk);
    rx_bnd = 1'b1;
    tx_bnd = 1'b1;
    @(negedge clk);
    rx_bnd = 1'b0;
    tx_bnd = 1'b0;
    chk({tx_err, rx_err}, {|exp[6:5], |exp[2:1]}, "slip error pulse");
    @(negedge clk);
    chk({tx_err, rx_err}, 8'h00, "slip error end");
    rd(`SSQ_ADDR_SLIP_STATUS, exp, "slip status");
    rd(`SSQ_ADDR_SLIP_STATUS, exp & 8'h88, "status after read");
    last_st = exp;
    $display("slip case %h done", ev);
  endtask

  task automatic sig_eval(input logic en, input logic [4:0] ch, input logic [3:0] i,
                          input logic [3:0] o);
    @(negedge clk);
    {eval, q_en, chan, abcd_in, abcd_out} = {1'b1, en, ch, i, o};
    @(negedge clk);
    eval = 1'b0;
  endtask

  task automatic mframe(input logic exp);
    @(negedge clk);
    mf_end = 1'b1;
    @(negedge clk);
    mf_end = 1'b0;
    chk(sig_irq, exp, "change interrupt");
    @(negedge clk);
    chk(sig_irq, 8'h00, "change interrupt end");
  endtask

  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    {clk, cpu_wr, cpu_rd, soft_reset, mode_t1, fstart, sync_in, sync_is_out} = 8'h00;
    {rx_bnd, rx_fs, rx_rep, rx_resync, rx_reass, tx_bnd, tx_fs, tx_rep, tx_bit} = 9'h000;
    {eval, q_en, mf_end, chan, abcd_in, abcd_out} = 16'h0000;
    {cpu_addr, cpu_wdata, last_st} = 24'h000000;
    insert_en = 1'b1;
    rx_cfg = SSQ_MODE_NORMAL;
    tx_cfg = SSQ_MODE_NORMAL;
    reset = 1'b1;
    // Rows: carrier T1, written offset, expected frame, signaling frame
    rows = '{{1'b1, 5'h00, 5'h01, 1'b0}, {1'b1, 5'h05, 5'h06, 1'b1},
             {1'b1, 5'h0b, 5'h0c, 1'b1}, {1'b1, 5'h17, 5'h18, 1'b1},
             {1'b0, 5'h00, 5'h00, 1'b0}, {1'b0, 5'h1f, 5'h0f, 1'b1},
             {1'b0, 5'h13, 5'h03, 1'b1}};
    repeat (16) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk({sig_irq, tx_err, rx_err, frame_no}, 8'h00, "outputs after reset");
    rd(`SSQ_ADDR_SYNC_FRAME, 8'h00, "offset reset");
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h00, "queue empty after reset");
    rd(8'hdb, `SSQ_RDATA_UNMAPPED, "unmapped read");
    $display("reset test done");
    foreach (rows[k]) begin
      mode_t1 = rows[k][11];
      wr(`SSQ_ADDR_SYNC_FRAME, {3'b111, rows[k][10:6]});
      rd(`SSQ_ADDR_SYNC_FRAME, {3'h0, rows[k][10:6]}, "offset readback");
      frame(1'b1);
      chk({sig_ins, sync_out, frame_no}, {rows[k][0], 1'b0, rows[k][5:1]}, "frame");
    end
    insert_en = 1'b0;
    #1;
    chk(sig_ins, 8'h00, "insertion disabled channel");
    $display("frame offset table done");
    mode_t1 = 1'b1;
    wr(`SSQ_ADDR_SYNC_FRAME, 8'h02);
    frame(1'b1);
    sync_is_out = 1'b1;
    for (int n = 1; n <= 24; n++) begin
      frame(1'b0);
      chk(sync_out, (n == 24), "sync output pulse");
    end
    $display("sync output test done");
    slip(7'b1100110, 8'hcc);
    slip(7'b0010001, 8'ha2);
    slip(7'b1000100, 8'h44);
    slip(7'b0001000, 8'h0a);
    slip(7'b1110111, 8'hee);
    {rx_cfg, tx_cfg} = {SSQ_MODE_ELASTIC, SSQ_MODE_ELASTIC};
    slip(7'b1110101, 8'ha2);
    {rx_cfg, tx_cfg} = {SSQ_MODE_BYPASS, SSQ_MODE_BYPASS};
    slip(7'h7f, 8'h80);
    {rx_cfg, tx_cfg} = {SSQ_MODE_SHORT, SSQ_MODE_SHORT};
    slip(7'b1000100, 8'h44);
    @(negedge clk);
    {rx_resync, tx_fs, tx_rep, rx_bnd, tx_bnd} = 5'h1f;
    @(negedge clk);
    {rx_resync, tx_fs, tx_rep, rx_bnd, tx_bnd} = 5'h00;
    chk({tx_err, rx_err}, 8'h03, "event in boundary cycle");
    rd(`SSQ_ADDR_SLIP_STATUS, 8'hc2, "boundary cycle slip");
    $display("boundary cycle test done");
    sig_eval(1'b1, 5'h03, 4'ha, 4'h5);
    sig_eval(1'b0, 5'h04, 4'hb, 4'h1);
    sig_eval(1'b1, 5'h05, 4'h7, 4'h7);
    mframe(1'b1);
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h43, "channel word");
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h8a, "last signaling word");
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h00, "empty word");
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h00, "empty word again");
    mframe(1'b0);
    for (int c = 1; c <= 5; c++)
      sig_eval(1'b1, 5'(c), 4'(c), 4'h0);
    for (int c = 1; c <= 4; c++) begin
      rd(`SSQ_ADDR_SIG_QUEUE, 8'h40 | 8'(c), "queued channel");
      rd(`SSQ_ADDR_SIG_QUEUE, {1'b1, c < 4, 2'b00, 4'(c)}, "queued signaling");
    end
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h00, "drained");
    sig_eval(1'b1, 5'h01, 4'h3, 4'h0);
    sig_eval(1'b1, 5'h02, 4'h4, 4'h0);
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h41, "before flush");
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h00, "after flush");
    mframe(1'b1);
    @(negedge clk);
    {eval, q_en, chan, abcd_in, abcd_out, mf_end} = {1'b1, 1'b1, 5'h07, 4'h9, 4'h0, 1'b1};
    @(negedge clk);
    {eval, mf_end} = 2'b00;
    chk(sig_irq, 8'h01, "change on closing cycle");
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h47, "closing cycle channel");
    rd(`SSQ_ADDR_SIG_QUEUE, 8'h89, "closing cycle signaling");
    $display("signaling queue test done");
    test_done();
  end
endmodule
`default_nettype wire
